// [rtl/acd_decoder.sv]
// Command decoder and configuration register of a serial converter.
// Assumes sclk_rise, cs_n, serial_in_pin are already synchronous strobes.
// Operation
// R1 - Top nibble is command, 12-bit data follows
// R2 - Eight-input: codes 0-7 select channels 0-7
// R3 - Four-input: even codes select inputs 0-3
// R4 - Code 8 enters software power-down
// R5 - Code 9 returns configuration in bits 11-0
// R6 - Code A writes 12 bits into configuration
// R7 - Codes B,C,D select midpoint, low, high test
// R8 - Code E outputs FIFO entry, low nibble zero
// R9 - Code F reserved, no action taken
// R10 - Host reads configuration only in single-shot; the decoder returns it in every conversion mode
// R11 - Configuration survives power-down
// R12 - Paused clock mid-write resumes accepting bits
// R13 - D11 selects external or internal reference
// R14 - D10 selects 4 V or 2 V
// R15 - D9 selects 12 or 24 clock sampling
// R16 - D8:7 selects conversion clock source
// R17 - D6:5 selects conversion mode
// R18 - D4:3 selects sweep channel order
// R19 - Sweep order used only in sweep modes
// R20 - D2 selects interrupt or end-of-conversion pin
// R21 - D1:0 sets FIFO trigger and sweep length
// R22 - Host shifts words MSB first
// R23 - Configuration read: four dummy bits first
// R24 - Input stops at 16 bits or chip-select rise
`timescale 1ns/1ps
module acd_decoder
    import acd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_n,            // Frame select, active low
    input wire logic sclk_rise,       // One-cycle strobe per serial clock
    input wire logic serial_in_pin,   // Serial data in
    input wire logic four_input,      // Variant strap: 1 = four inputs
    input wire logic [11:0] fifo_data, // Next FIFO entry
    output logic serial_out_pin,      // Serial data out
    output logic serial_out_oe_n,     // Low while driving serial out
    output logic [3:0] input_sel,     // Multiplexer selection
    output logic conv_start,          // Pulse: conversion command decoded
    output logic fifo_pop,            // Pulse: FIFO entry taken
    output logic power_down,          // Software power-down level
    output logic ref_internal,
    output logic ref_2v,
    output logic [4:0] sample_clocks,
    output logic [1:0] conv_clk_sel,
    output logic [1:0] conv_mode,
    output logic [1:0] sweep_order,
    output logic pin_is_eoc,
    output logic [3:0] sweep_len
);
    import acd_pkg::*;

    // Whole module state in one struct
    typedef struct packed {
        acd_state_e st;
        logic [4:0] cnt;        // Bits taken this frame
        logic [15:0] shin;      // Input shift register
        logic [15:0] shout;     // Output shift register
        logic [11:0] cfg;       // Configuration register
        logic so;
        logic so_oe_n;
        logic [3:0] sel;
        logic start;
        logic pop;
        logic pd;
        logic [4:0] smp;        // Registered sampling length
        logic [1:0] ord;        // Registered sweep order
        logic [3:0] slen;       // Registered sweep length
    } acd_s;

    acd_s q_r, q_nxt;

    // Trigger code to sweep length
    function automatic logic [3:0] trig_len(input logic [1:0] t);
        case (t)
            2'b00: trig_len = TRIG_L0;
            2'b01: trig_len = TRIG_L1;
            2'b10: trig_len = TRIG_L2;
            default: trig_len = TRIG_L3;
        endcase
    endfunction

    logic [15:0] word_in;
    assign word_in = {q_r.shin[14:0], serial_in_pin};

    // Next-state logic for the serial frame
    always_comb begin
        q_nxt = q_r;
        q_nxt.start = 1'b0;
        q_nxt.pop = 1'b0;
        case (q_r.st)
            ST_IDLE: begin
                q_nxt.so_oe_n = 1'b1;
                q_nxt.cnt = 5'h00;
                // Frame opens on chip-select low
                if (!cs_n) begin
                    q_nxt.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_n) begin
                    // Early rise ends input; a partial write is dropped
                    q_nxt.st = ST_IDLE; // R24
                end else if (sclk_rise) begin
                    // No timeout: a paused clock simply waits
                    q_nxt.shin = word_in; // R12 R22
                    q_nxt.cnt = q_r.cnt + 5'h01;
                    q_nxt.so = q_r.shout[15];
                    q_nxt.shout = {q_r.shout[14:0], 1'b0};
                    if (q_r.cnt + 5'h01 == BITS_CMD) begin
                        // Command nibble complete
                        q_nxt.so_oe_n = 1'b0; // R1
                        if (!word_in[3]) begin
                            // Channel select; four-input uses even codes
                            if (!four_input) begin
                                q_nxt.sel = word_in[3:0]; // R2
                                q_nxt.start = 1'b1;
                            end else if (!word_in[0]) begin
                                q_nxt.sel = {2'b00, word_in[2:1]}; // R3
                                q_nxt.start = 1'b1;
                            end
                        end else if (word_in[3:0] == CMD_PWRDN) begin
                            q_nxt.pd = 1'b1; // R4 R11
                        end else if (word_in[3:0] == CMD_TEST_MID) begin
                            q_nxt.sel = SEL_MID; // R7
                            q_nxt.start = 1'b1;
                        end else if (word_in[3:0] == CMD_TEST_LOW) begin
                            q_nxt.sel = SEL_LOW; // R7
                            q_nxt.start = 1'b1;
                        end else if (word_in[3:0] == CMD_TEST_HIGH) begin
                            q_nxt.sel = SEL_HIGH; // R7
                            q_nxt.start = 1'b1;
                        end
                        // Code F: nothing, R9; every code but 8 and F clears power-down
                        if (word_in[3:0] != CMD_PWRDN &&
                            word_in[3:0] != 4'hf) begin
                            q_nxt.pd = 1'b0;
                        end
                    end
                    if (q_r.cnt + 5'h01 == BITS_WORD) begin
                        q_nxt.st = ST_DONE; // R24
                        if (word_in[15:12] == CMD_CFG_WR) begin
                            q_nxt.cfg = word_in[11:0]; // R6
                        end
                    end
                end
            end
            default: begin
                // Ignore input until chip select rises
                if (cs_n) begin
                    q_nxt.st = ST_IDLE;
                end
            end
        endcase
        // Output word loaded at frame start with the next FIFO entry.
        // The command is not known yet, so the FIFO word must already be
        // leading; a FIFO read then shows it in bits 15 to 4.
        if (q_r.st == ST_IDLE && !cs_n) begin
            q_nxt.shout = {fifo_data, 4'h0}; // R8
        end
        // Configuration read loads the output after the nibble; FIFO read only pops
        if (q_r.st == ST_SHIFT && !cs_n && sclk_rise &&
            q_r.cnt + 5'h01 == BITS_CMD) begin
            if (word_in[3:0] == CMD_CFG_RD) begin
                // Four dummy bits already sent, contents follow
                q_nxt.shout = {q_r.cfg, 4'h0}; // R5 R23 R10
            end else if (word_in[3:0] == CMD_FIFO_RD) begin
                // Entry is already shifting out; only take it from the
                // FIFO so the next read sees the following entry
                q_nxt.pop = 1'b1; // R8
            end
        end
        // Decoded fields follow the next register value, so they change
        // in the same cycle as the register and leave from flops
        if (q_nxt.cfg[CFG_SAMPLE]) begin
            q_nxt.smp = SAMPLE_LONG; // R15
        end else begin
            q_nxt.smp = SAMPLE_SHORT; // R15
        end
        // Sweep order only matters in the two sweep modes
        if (q_nxt.cfg[CFG_MODE_HI]) begin
            q_nxt.ord = q_nxt.cfg[CFG_SWP_HI:CFG_SWP_LO]; // R18 R19
        end else begin
            q_nxt.ord = 2'b00; // R19
        end
        // Trigger level doubles as the sweep length
        q_nxt.slen = trig_len(q_nxt.cfg[CFG_TRIG_HI:CFG_TRIG_LO]); // R21
    end

    // State register; configuration not cleared by power-down
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= '{st: ST_IDLE, cnt: 5'h00, shin: 16'h0000,
                     shout: 16'h0000, cfg: CFG_RESET, so: 1'b0,
                     so_oe_n: 1'b1, sel: 4'h0, start: 1'b0,
                     pop: 1'b0, pd: 1'b0, smp: SAMPLE_SHORT,
                     ord: 2'b00, slen: TRIG_L0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from state flops
    assign serial_out_pin = q_r.so;
    assign serial_out_oe_n = q_r.so_oe_n;
    assign input_sel = q_r.sel;
    assign conv_start = q_r.start;
    assign fifo_pop = q_r.pop;
    assign power_down = q_r.pd;
    assign ref_internal = q_r.cfg[CFG_REF_SRC]; // R13
    assign ref_2v = q_r.cfg[CFG_REF_LVL]; // R14
    assign sample_clocks = q_r.smp; // R15
    assign conv_clk_sel = q_r.cfg[CFG_CLK_HI:CFG_CLK_LO]; // R16
    assign conv_mode = q_r.cfg[CFG_MODE_HI:CFG_MODE_LO]; // R17
    // Sweep order forced to zero outside sweep modes
    assign sweep_order = q_r.ord; // R18 R19
    assign pin_is_eoc = q_r.cfg[CFG_PIN_FN]; // R20
    assign sweep_len = q_r.slen; // R21

    // Assertions

    // Command nibble complete in this cycle
    sequence s_nibble_done;
        q_r.st == ST_SHIFT && !cs_n && sclk_rise && q_r.cnt == 5'h03;
    endsequence

    a_fifo_pop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_nibble_done ##0 (word_in[3:0] == CMD_FIFO_RD) |=> fifo_pop)
        else $error("fifo entry not taken"); // R8
    a_pd_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_nibble_done ##0 (word_in[3:0] == CMD_PWRDN) |=> power_down)
        else $error("power-down not entered"); // R4
    a_test_mid: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_nibble_done ##0 (word_in[3:0] == CMD_TEST_MID)
        |=> conv_start && input_sel == SEL_MID)
        else $error("midpoint test not selected"); // R7
    a_reserved_quiet: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        s_nibble_done ##0 (word_in[3:0] == 4'hf)
        |=> !conv_start && !fifo_pop && $stable(power_down))
        else $error("reserved code acted"); // R9
    a_four_odd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_nibble_done ##0 (four_input && !word_in[3] && word_in[0])
        |=> !conv_start)
        else $error("odd code started on four inputs"); // R3
    a_out_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_nibble_done |=> !serial_out_oe_n)
        else $error("serial out not driven after nibble"); // R1
    a_cfg_write_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q_r.st == ST_SHIFT && !cs_n && sclk_rise && q_r.cnt == 5'h0f &&
         word_in[15:12] == CMD_CFG_WR) |=> q_r.cfg == $past(word_in[11:0]))
        else $error("config write not stored"); // R6
    a_cs_rise_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q_r.st == ST_SHIFT && cs_n) |=> q_r.st == ST_IDLE)
        else $error("input not stopped on cs rise"); // R24
    a_sixteen_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q_r.st == ST_SHIFT && !cs_n && sclk_rise && q_r.cnt == 5'h0f)
        |=> q_r.st == ST_DONE)
        else $error("input not stopped at 16"); // R24
    a_pd_keep_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q_r.pd && !(q_r.st == ST_SHIFT && sclk_rise)) |=> $stable(q_r.cfg))
        else $error("config lost in power-down"); // R11
    a_pause_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q_r.st == ST_SHIFT && !cs_n && !sclk_rise) |=> $stable(q_r.cnt))
        else $error("bit count moved while clock paused"); // R12
    a_sample_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_clocks == (q_r.cfg[9] ? 5'h18 : 5'h0c))
        else $error("sampling length wrong"); // R15
    a_sweep_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !q_r.cfg[6] |-> sweep_order == 2'b00)
        else $error("sweep order used outside sweep"); // R19
    a_cmd_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q_r.st == ST_SHIFT && !cs_n && sclk_rise && q_r.cnt == 5'h03 &&
         !four_input && !word_in[3]) |=> conv_start && input_sel ==
         $past(word_in[3:0]))
        else $error("channel select not decoded"); // R2
endmodule

// [rtl/acd_pkg.sv]
// Package for the converter command decoder: command codes, configuration
// field positions and bit counts.
// Assumes one system clock; serial pins are synchronous to it.
package acd_pkg;
    // Command codes in the top four bits of a serial word
    localparam logic [3:0] CMD_PWRDN = 4'h8;
    localparam logic [3:0] CMD_CFG_RD = 4'h9;
    localparam logic [3:0] CMD_CFG_WR = 4'ha;
    localparam logic [3:0] CMD_TEST_MID = 4'hb;
    localparam logic [3:0] CMD_TEST_LOW = 4'hc;
    localparam logic [3:0] CMD_TEST_HIGH = 4'hd;
    localparam logic [3:0] CMD_FIFO_RD = 4'he;
    // Configuration field positions
    localparam int CFG_REF_SRC = 11;
    localparam int CFG_REF_LVL = 10;
    localparam int CFG_SAMPLE = 9;
    localparam int CFG_CLK_HI = 8;
    localparam int CFG_CLK_LO = 7;
    localparam int CFG_MODE_HI = 6;
    localparam int CFG_MODE_LO = 5;
    localparam int CFG_SWP_HI = 4;
    localparam int CFG_SWP_LO = 3;
    localparam int CFG_PIN_FN = 2;
    localparam int CFG_TRIG_HI = 1;
    localparam int CFG_TRIG_LO = 0;
    // Value after reset, before software writes the register
    localparam logic [11:0] CFG_RESET = 12'h000;
    // Bit counts of a frame
    localparam logic [4:0] BITS_CMD = 5'h04;
    localparam logic [4:0] BITS_WORD = 5'h10;
    // Sampling lengths in serial clocks
    localparam logic [4:0] SAMPLE_SHORT = 5'h0c;
    localparam logic [4:0] SAMPLE_LONG = 5'h18;
    // Input selections driven to the multiplexer
    localparam logic [3:0] SEL_MID = 4'h8;
    localparam logic [3:0] SEL_LOW = 4'h9;
    localparam logic [3:0] SEL_HIGH = 4'ha;
    // Sweep lengths by trigger code
    localparam logic [3:0] TRIG_L0 = 4'h7;
    localparam logic [3:0] TRIG_L1 = 4'h5;
    localparam logic [3:0] TRIG_L2 = 4'h3;
    localparam logic [3:0] TRIG_L3 = 4'h1;
    // Frame state
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} acd_state_e;
endpackage

// [dv/acd_host.sv]
// Host serial port model that frames 16-bit command words into the decoder.
// Assumes the bench clock; drives pins only on the falling edge.
`timescale 1ns/1ps
module acd_host (
    input wire logic clk_sys,
    output logic cs_n,
    output logic sclk_rise,
    output logic serial_in_pin,
    input wire logic serial_out_pin
);
    // Idle pins before the first frame
    initial begin
        cs_n = 1'b1;
        sclk_rise = 1'b0;
        serial_in_pin = 1'b0;
    end

    // One frame: nbits serial clocks, optional stall after the eighth bit
    task automatic frame(input logic [15:0] word, input int nbits,
                         input int pause, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk_sys);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            @(negedge clk_sys);
            // Bits past the sixteenth are filler the device must ignore
            serial_in_pin = (i < 16) ? word[15 - i] : 1'b1;
            sclk_rise = 1'b1;
            @(negedge clk_sys);
            sclk_rise = 1'b0;
            // Output is registered, so read it a cycle after the bit
            if (i < 16) begin
                rx[15 - i] = serial_out_pin;
            end
            // Serial clock stands still during the stall
            if (i == 7) begin
                repeat (pause) @(negedge clk_sys);
            end
        end
        @(negedge clk_sys);
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        serial_in_pin = ~serial_in_pin;
        repeat (2) @(negedge clk_sys);
    endtask
endmodule

// [dv/acd_decoder_bench.sv]
// Self-checking bench for the converter command decoder.
// Assumes the host model drives the serial pins; checks ports only.
`timescale 1ns/1ps
module acd_decoder_bench;
    import acd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, sclk_rise, serial_in_pin, serial_out_pin, serial_out_oe_n;
    logic four_input = 1'b0;
    logic [11:0] fifo_data = 12'h000;
    logic [3:0] input_sel, sweep_len;
    logic conv_start, fifo_pop, power_down, ref_internal, ref_2v, pin_is_eoc;
    logic [4:0] sample_clocks;
    logic [1:0] conv_clk_sel, conv_mode, sweep_order;
    int num_errors = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_pop = 0;
    logic [31:0] lfsr = 32'hce8ef221;
    logic [15:0] rx;
    logic [11:0] v;

    acd_decoder acd_decoder_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .cs_n(cs_n), .sclk_rise(sclk_rise), .serial_in_pin(serial_in_pin),
        .four_input(four_input), .fifo_data(fifo_data),
        .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
        .input_sel(input_sel), .conv_start(conv_start), .fifo_pop(fifo_pop),
        .power_down(power_down), .ref_internal(ref_internal),
        .ref_2v(ref_2v), .sample_clocks(sample_clocks),
        .conv_clk_sel(conv_clk_sel), .conv_mode(conv_mode),
        .sweep_order(sweep_order), .pin_is_eoc(pin_is_eoc),
        .sweep_len(sweep_len));
    acd_host acd_host_i (.clk_sys(clk_sys), .cs_n(cs_n),
        .sclk_rise(sclk_rise), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin));

    // 100 ns period
    always #50 clk_sys = ~clk_sys;

    // Count the one-cycle pulses so a missed or doubled one shows
    always @(negedge clk_sys) begin
        if (conv_start === 1'b1) n_start++;
        if (fifo_pop === 1'b1) n_pop++;
    end

    // Galois shift register; fixed start keeps runs repeatable
    function automatic logic [31:0] rnd();
        lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h80200003 : 32'h0);
        return lfsr;
    endfunction

    // Expected multiplexer selection; four inputs use even codes only
    function automatic logic [3:0] exp_sel(input logic [3:0] c,
                                           input logic f);
        if (c == CMD_TEST_MID) return 4'h8;
        if (c == CMD_TEST_LOW) return 4'h9;
        if (c == CMD_TEST_HIGH) return 4'ha;
        return f ? {1'b0, c[3:1]} : c;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Decoded configuration fields against a register value
    task automatic chk_cfg(input logic [11:0] c);
        chk("ref_internal", c[11], ref_internal);
        chk("ref_2v", c[10], ref_2v);
        chk("sample_clocks", c[9] ? 16'h0018 : 16'h000c, sample_clocks);
        chk("conv_clk_sel", c[8:7], conv_clk_sel);
        chk("conv_mode", c[6:5], conv_mode);
        chk("sweep_order", c[6] ? c[4:3] : 2'h0, sweep_order);
        chk("pin_is_eoc", c[2], pin_is_eoc);
        chk("sweep_len", 4'h7 - {1'b0, c[1:0], 1'b0}, sweep_len);
    endtask

    // Configuration read; contents sit in the last twelve bits
    task automatic rd_cfg(input logic [11:0] c);
        acd_host_i.frame({CMD_CFG_RD, 12'h000}, 16, 0, rx);
        chk("cfg_read", c, rx[11:0]);
    endtask

    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well past the length of the sequence below
    initial begin
        repeat (30000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        chk_cfg(CFG_RESET);
        // Every command code on both variants, register codes and four-input odd channel codes apart
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 16; c++) begin
                if (c == 9 || c == 10 || (f == 1 && c < 8 && c % 2 == 1))
                    continue;
                four_input = f[0];
                fifo_data = 12'(rnd());
                n_start = 0;
                n_pop = 0;
                acd_host_i.frame({c[3:0], 12'h000}, 16, 0, rx);
                chk("conv_start", (c < 8 || (c > 10 && c < 14)) ? 1 : 0,
                    n_start[15:0]);
                chk("power_down", c == 8, power_down);
                chk("fifo_pop", c == 14, n_pop[15:0]);
                if (c == 14) chk("fifo_low", 4'h0, rx[3:0]);
                if (c == 14) chk("fifo_word", fifo_data, rx[15:4]);
                chk("serial_out_oe_n", 1'b1, serial_out_oe_n);
                if (c < 8 || (c > 10 && c < 14))
                    chk("input_sel", exp_sel(c[3:0], f[0]), input_sel);
            end
        end
        // Corner values then random ones, with clock stalls mid-write
        for (int i = 0; i < 10; i++) begin
            v = (i < 4) ? {3{4'(i * 5)}} : 12'(rnd());
            acd_host_i.frame({CMD_CFG_WR, v}, 16, i * 3, rx);
            chk_cfg(v);
            v[6:5] = 2'h0;
            acd_host_i.frame({CMD_CFG_WR, v}, 16, 0, rx);
            acd_host_i.frame({CMD_PWRDN, 12'h000}, 16, 0, rx);
            rd_cfg(v);
        end
        // Aborted write, overlong frame and reserved code
        acd_host_i.frame({CMD_CFG_WR, ~v}, 8, 0, rx);
        rd_cfg(v);
        acd_host_i.frame({CMD_CFG_WR, 12'h59a}, 20, 0, rx);
        rd_cfg(12'h59a);
        acd_host_i.frame({4'hf, 12'ha65}, 16, 0, rx);
        rd_cfg(12'h59a);
        chk_cfg(12'h59a);
        stop_test();
    end
endmodule
